// >>> hdl/xsc_chain.sv
// Serial configuration front end of the 4x4 crosspoint
// Summary of operation
// - Configuration arrives as 30-bit words; six leading bits are the start frame.
// - Only frame 1F (load) and 1E (read-back) are accepted; others are ignored.
// - Words are shifted most significant bit first, bit 29 earliest.
// - Row address in bits 23..18, column address in bits 17..12.
// - Four 3-bit selection fields occupy bits 11..0, output one highest.
// - Code 000 disables an output; 001..011 select inputs one to three.
// - Code 100 connects the output to input four.
// - Frame search is continuous; a load frame with zero row and column captures fields into load register.
// - Column port decrements the row address; row port decrements the column address.
// - Incoming stream is replicated on row and column clock/data pairs.
// - Data reaches the forward outputs after seven serial clock rising edges.
// - Load pulse copies the load register into the active configuration at once.
// - A read frame with zero row and column inserts the configuration into the fields on both outputs.
// - Read-back words carry an all-ones address, decremented by each downstream device.
// - After inserting its configuration the device returns to write mode.
`timescale 1ns/100ps
`default_nettype none
`include "xsc_map.svh"

module xsc_chain
	import xsc_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          ser_clk,
	input  wire logic          ser_data,
	input  wire logic          load_pulse,
	input  wire xsc_axi_req_t  axi_req,
	output xsc_axi_resp_t      axi_resp,
	output logic               row_fwd_clock,
	output logic               row_fwd_data,
	output logic               column_fwd_clock,
	output logic               column_fwd_data,
	output logic [2:0]         output_one_select,
	output logic [2:0]         output_two_select,
	output logic [2:0]         output_three_select,
	output logic [2:0]         output_four_select,
	output logic [3:0]         output_enable,
	output logic [7:0]         output_source
);

	xsc_core_t r_r;
	xsc_core_t r_nxt;

	logic       se;
	logic       ld_rise;
	logic       b;
	logic [5:0] win_nxt;
	logic [4:0] cnt_inc;
	logic [4:0] ins_idx;
	logic       pipe_bit;
	logic       col_patch;
	logic [5:0] col_patch_val;
	logic       row_patch;
	logic [5:0] row_patch_val;
	logic       hit_now;
	logic       aw_rdy;
	logic       w_rdy;
	logic       ar_rdy;

	// Edge detection looks only at the second synchroniser stage
	assign se      = r_r.ck_sy[1] & ~r_r.ck_prev;
	assign ld_rise = r_r.ld_sy[1] & ~r_r.ld_prev;
	assign b       = r_r.dt_sy[1];
	assign win_nxt = {r_r.win[4:0], b};
	assign cnt_inc = r_r.cnt + 5'h01;
	assign ins_idx = `XSC_SEL_LAST - r_r.cnt;

	// One write and one read in flight; ready drops while an answer waits
	assign aw_rdy = ~r_r.aw_got & ~r_r.bvalid;
	assign w_rdy  = ~r_r.w_got & ~r_r.bvalid;
	assign ar_rdy = ~r_r.rvalid;

	// Whole next state of the block
	always_comb begin
		r_nxt         = r_r;
		col_patch     = 1'b0;
		col_patch_val = `XSC_ADDR_ZERO;
		row_patch     = 1'b0;
		row_patch_val = `XSC_ADDR_ZERO;
		hit_now       = 1'b0;
		pipe_bit      = b;
		r_nxt.ck_sy   = {r_r.ck_sy[0], ser_clk};
		r_nxt.ck_prev = r_r.ck_sy[1];
		r_nxt.dt_sy   = {r_r.dt_sy[0], ser_data};
		r_nxt.ld_sy   = {r_r.ld_sy[0], load_pulse};
		r_nxt.ld_prev = r_r.ld_sy[1];
		r_nxt.fck     = {r_r.fck[0], r_r.ck_sy[1]};
		r_nxt.sw_ld   = 1'b0;

		// Word framing on each serial rising edge
		if (se) begin
			case (r_r.state)
				XSC_HUNT: begin
					r_nxt.win = win_nxt;
					if (win_nxt == `XSC_FRAME_LOAD || win_nxt == `XSC_FRAME_READ) begin
						r_nxt.state   = XSC_WORD;
						r_nxt.cnt     = `XSC_CNT_FRAME;
						r_nxt.is_read = (win_nxt == `XSC_FRAME_READ);
						r_nxt.hit     = 1'b0;
					end
				end
				XSC_WORD: begin
					r_nxt.cnt = cnt_inc;
					if (r_r.cnt < `XSC_CNT_ROW) begin
						r_nxt.row = {r_r.row[4:0], b};
					end else if (r_r.cnt < `XSC_CNT_COL) begin
						r_nxt.col = {r_r.col[4:0], b};
					end else begin
						r_nxt.sel = {r_r.sel[10:0], b};
					end
					if (cnt_inc == `XSC_CNT_ROW) begin
						col_patch     = 1'b1;
						col_patch_val = r_nxt.row - `XSC_ADDR_ONE;
					end
					if (cnt_inc == `XSC_CNT_COL) begin
						hit_now   = (r_r.row == `XSC_ADDR_ZERO) && (r_nxt.col == `XSC_ADDR_ZERO);
						r_nxt.hit = hit_now;
						row_patch = 1'b1;
						if (hit_now && r_r.is_read) begin
							row_patch_val = `XSC_ADDR_ONES;
							r_nxt.state   = XSC_INSERT;
						end else begin
							row_patch_val = r_nxt.col - `XSC_ADDR_ONE;
						end
					end
					if (cnt_inc == `XSC_CNT_WORD) begin
						if (r_r.hit && !r_r.is_read) begin
							r_nxt.load_reg = r_nxt.sel;
						end
						r_nxt.state = XSC_HUNT;
						r_nxt.win   = `XSC_WIN_RST;
					end
				end
				XSC_INSERT: begin
					r_nxt.cnt = cnt_inc;
					pipe_bit  = r_r.cfg[ins_idx[3:0]];
					if (cnt_inc == `XSC_CNT_WORD) begin
						r_nxt.state = XSC_HUNT;
						r_nxt.win   = `XSC_WIN_RST;
					end
				end
				default: begin
					r_nxt.state = XSC_HUNT;
				end
			endcase
		end

		// Pin load or software load moves all four fields at once
		if (ld_rise || r_r.sw_ld) begin
			r_nxt.cfg = r_r.load_reg;
		end

		// Write channel: address and data taken in either order
		if (axi_req.awvalid && aw_rdy) begin
			r_nxt.aw_got  = 1'b1;
			r_nxt.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && w_rdy) begin
			r_nxt.w_got = 1'b1;
			r_nxt.w_ld  = axi_req.wdata[`XSC_CTRL_LOAD] & axi_req.wstrb[0];
		end
		if (r_r.aw_got && r_r.w_got) begin
			r_nxt.aw_got = 1'b0;
			r_nxt.w_got  = 1'b0;
			r_nxt.bvalid = 1'b1;
			if (r_r.aw_addr == `XSC_OFS_CTRL) begin
				r_nxt.bresp = `XSC_RESP_OKAY;
				r_nxt.sw_ld = r_r.w_ld;
			end else if (r_r.aw_addr == `XSC_OFS_STATUS) begin
				r_nxt.bresp = `XSC_RESP_OKAY;
			end else if (r_r.aw_addr == `XSC_OFS_LOADREG) begin
				r_nxt.bresp = `XSC_RESP_OKAY;
			end else if (r_r.aw_addr == `XSC_OFS_CFG) begin
				r_nxt.bresp = `XSC_RESP_OKAY;
			end else begin
				r_nxt.bresp = `XSC_RESP_SLVERR;
			end
		end
		if (r_r.bvalid && axi_req.bready) begin
			r_nxt.bvalid = 1'b0;
		end

		// Read channel: one-cycle answer from the register image
		if (axi_req.arvalid && ar_rdy) begin
			r_nxt.rvalid = 1'b1;
			r_nxt.rresp  = `XSC_RESP_OKAY;
			if (axi_req.araddr == `XSC_OFS_CTRL) begin
				r_nxt.rdata = 32'h0000_0000;
			end else if (axi_req.araddr == `XSC_OFS_STATUS) begin
				r_nxt.rdata = {23'h00_0000, r_r.hit, r_r.is_read, r_r.state, r_r.cnt};
			end else if (axi_req.araddr == `XSC_OFS_LOADREG) begin
				r_nxt.rdata = {20'h0_0000, r_r.load_reg};
			end else if (axi_req.araddr == `XSC_OFS_CFG) begin
				r_nxt.rdata = {20'h0_0000, r_r.cfg};
			end else begin
				r_nxt.rdata = 32'h0000_0000;
				r_nxt.rresp = `XSC_RESP_SLVERR;
			end
		end
		if (r_r.rvalid && axi_req.rready) begin
			r_nxt.rvalid = 1'b0;
		end
	end

	// Single state register; reset leaves the switch fully disabled
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r_r       <= '0;
			r_r.state <= XSC_HUNT;
			r_r.cfg   <= `XSC_CFG_RST;
		end else begin
			r_r <= r_nxt;
		end
	end

	// Row port carries the column-decremented copy
	xsc_fwd_pipe u_row_pipe (
		.clk       (clk),
		.nrst      (nrst),
		.shift     (se),
		.bit_in    (pipe_bit),
		.patch     (row_patch),
		.patch_val (row_patch_val),
		.data_out  (row_fwd_data)
	);

	// Column port carries the row-decremented copy
	xsc_fwd_pipe u_col_pipe (
		.clk       (clk),
		.nrst      (nrst),
		.shift     (se),
		.bit_in    (pipe_bit),
		.patch     (col_patch),
		.patch_val (col_patch_val),
		.data_out  (column_fwd_data)
	);

	// Forwarded clocks lag data by a cycle so data is settled at their rise
	assign row_fwd_clock    = r_r.fck[1];
	assign column_fwd_clock = r_r.fck[1];

	// Per-output decode: 0 is off, 1..4 pick an input
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_out
			logic [2:0] code;
			logic [2:0] idx;
			assign code = r_r.cfg[`XSC_SEL_W*(3-gi) +: `XSC_SEL_W];
			assign idx  = code - 3'h1;
			assign output_enable[gi]        = (code != `XSC_SEL_OFF);
			assign output_source[2*gi +: 2] = idx[1:0];
		end
	endgenerate

	assign output_one_select   = r_r.cfg[11:9];
	assign output_two_select   = r_r.cfg[8:6];
	assign output_three_select = r_r.cfg[5:3];
	assign output_four_select  = r_r.cfg[2:0];

	// Bus answers; the handshake readies are combinational
	always_comb begin
		axi_resp         = '0;
		axi_resp.awready = aw_rdy;
		axi_resp.wready  = w_rdy;
		axi_resp.bvalid  = r_r.bvalid;
		axi_resp.bresp   = r_r.bresp;
		axi_resp.arready = ar_rdy;
		axi_resp.rvalid  = r_r.rvalid;
		axi_resp.rdata   = r_r.rdata;
		axi_resp.rresp   = r_r.rresp;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_hunt_edge;
		(r_r.state == XSC_HUNT) && se;
	endsequence

	sequence s_addr_done;
		(r_r.state == XSC_WORD) && se && (cnt_inc == `XSC_CNT_COL);
	endsequence

	sequence s_word_end;
		(r_r.state == XSC_WORD) && se && (cnt_inc == `XSC_CNT_WORD);
	endsequence

	frame_detect_a: assert property (
		s_hunt_edge ##0 (win_nxt == `XSC_FRAME_LOAD || win_nxt == `XSC_FRAME_READ)
		|=> (r_r.state == XSC_WORD) && (r_r.cnt == `XSC_CNT_FRAME))
		else $error("start frame not detected");

	frame_ignore_a: assert property (
		s_hunt_edge ##0 (win_nxt != `XSC_FRAME_LOAD && win_nxt != `XSC_FRAME_READ)
		|=> r_r.state == XSC_HUNT)
		else $error("invalid frame accepted");

	load_capture_a: assert property (
		s_word_end ##0 (r_r.hit && !r_r.is_read) |=> r_r.load_reg == $past(r_nxt.sel))
		else $error("addressed word not captured");

	load_guard_a: assert property (
		s_word_end ##0 !r_r.hit |=> $stable(r_r.load_reg))
		else $error("forwarded word altered load register");

	read_enter_a: assert property (
		s_addr_done ##0 (hit_now && r_r.is_read)
		|=> (r_r.state == XSC_INSERT) [*1] ##1 (r_r.state == XSC_INSERT))
		else $error("read hit did not enter insert");

	read_return_a: assert property (
		(r_r.state == XSC_INSERT) && se && (cnt_inc == `XSC_CNT_WORD)
		|=> (r_r.state == XSC_HUNT) && (r_r.win == `XSC_WIN_RST))
		else $error("no return to write mode");

	read_addr_a: assert property (
		s_addr_done ##0 (hit_now && r_r.is_read) |-> row_patch_val == `XSC_ADDR_ONES)
		else $error("read-back address not all ones");

	cfg_update_a: assert property (
		ld_rise |=> r_r.cfg == $past(r_r.load_reg))
		else $error("load pulse did not update configuration");

	cfg_hold_a: assert property (
		!ld_rise && !r_r.sw_ld |=> $stable(r_r.cfg))
		else $error("configuration changed without load");

	fwd_clock_a: assert property (
		se |=> ##1 row_fwd_clock && column_fwd_clock)
		else $error("forwarded clock missing");

	out_decode_a: assert property (
		output_one_select == `XSC_SEL_OFF |-> !output_enable[0])
		else $error("disabled output still enabled");

endmodule
`default_nettype wire

// >>> hdl/xsc_map.svh
// Constants of the crosspoint serial configuration chain
`ifndef XSC_MAP_SVH
`define XSC_MAP_SVH

// Control word framing
`define XSC_FRAME_LOAD   6'h1F
`define XSC_FRAME_READ   6'h1E
`define XSC_CNT_FRAME    5'h06
`define XSC_CNT_ROW      5'h0C
`define XSC_CNT_COL      5'h12
`define XSC_CNT_WORD     5'h1E
`define XSC_SEL_LAST     5'h1D
`define XSC_ADDR_ONES    6'h3F
`define XSC_ADDR_ONE     6'h01
`define XSC_ADDR_ZERO    6'h00

// Selection field codes
`define XSC_SEL_OFF      3'h0
`define XSC_SEL_W        3

// Reset values
`define XSC_CFG_RST      12'h000
`define XSC_WIN_RST      6'h00

// Register offsets (byte addresses)
`define XSC_OFS_CTRL     32'h0000_0000
`define XSC_OFS_STATUS   32'h0000_0004
`define XSC_OFS_LOADREG  32'h0000_0008
`define XSC_OFS_CFG      32'h0000_000C
`define XSC_CTRL_LOAD    0

// Bus responses
`define XSC_RESP_OKAY    2'h0
`define XSC_RESP_SLVERR  2'h2

`endif

// >>> hdl/xsc_pkg.sv
// Types of the crosspoint serial configuration chain
package xsc_pkg;

	typedef enum logic [1:0] {
		XSC_HUNT   = 2'b00,
		XSC_WORD   = 2'b01,
		XSC_INSERT = 2'b10
	} xsc_state_t;

	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} xsc_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} xsc_axi_resp_t;

	typedef struct packed {
		logic [6:0] bits;
	} xsc_pipe_t;

	typedef struct packed {
		logic [1:0]  ck_sy;
		logic        ck_prev;
		logic [1:0]  dt_sy;
		logic [1:0]  ld_sy;
		logic        ld_prev;
		logic [1:0]  fck;
		xsc_state_t  state;
		logic [4:0]  cnt;
		logic        is_read;
		logic        hit;
		logic [5:0]  win;
		logic [5:0]  row;
		logic [5:0]  col;
		logic [11:0] sel;
		logic [11:0] load_reg;
		logic [11:0] cfg;
		logic        sw_ld;
		logic        aw_got;
		logic [31:0] aw_addr;
		logic        w_got;
		logic        w_ld;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} xsc_core_t;

endpackage

// >>> hdl/xsc_fwd_pipe.sv
// Seven-stage forwarding pipe with an address patch port
`timescale 1ns/100ps
`default_nettype none
`include "xsc_map.svh"

module xsc_fwd_pipe
	import xsc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       shift,
	input  wire logic       bit_in,
	input  wire logic       patch,
	input  wire logic [5:0] patch_val,
	output logic            data_out
);

	xsc_pipe_t r_r;
	xsc_pipe_t r_nxt;

	// Shift one bit per serial edge; a patch rewrites the newest six bits
	always_comb begin
		r_nxt = r_r;
		if (shift) begin
			r_nxt.bits = {r_r.bits[5:0], bit_in};
			if (patch) begin
				r_nxt.bits[5:0] = patch_val;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	// Oldest stage drives the pin straight from a flop
	assign data_out = r_r.bits[6];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	patch_apply_a: assert property (
		shift && patch |=> r_r.bits[5:0] == $past(patch_val))
		else $error("address patch not applied");

	out_hold_a: assert property (
		!shift |=> $stable(data_out))
		else $error("forward data moved without a serial edge");

endmodule
`default_nettype wire

// >>> bench/xsc_host_model.sv
// Host controller model driving the serial configuration pins
`timescale 1ns/100ps
`default_nettype none

module xsc_host_model (
	input  wire logic clk,
	output logic      ser_clk,
	output logic      ser_data,
	output logic      load_pulse
);
	// Pins start low; the serial clock stands still between frames
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		load_pulse = 1'b0;
	end

	// One bit: data set while clock low, four clk per phase for the synchroniser
	task automatic send_bit(input logic b);
		@(posedge clk);
		ser_data <= b;
		repeat (4) @(posedge clk);
		ser_clk <= 1'b1;
		repeat (4) @(posedge clk);
		ser_clk <= 1'b0;
	endtask

	// Whole word MSB first, then zeros so that it leaves the pipe
	task automatic send_word(input logic [29:0] w);
		for (int i = 29; i >= 0; i--) send_bit(w[i]);
		for (int i = 0; i < 6; i++) send_bit(1'b0);
		@(posedge clk);
		ser_data <= 1'b1; // Undriven line shows the inverse of the last bit
	endtask

	// Shared load, only after the word has surely settled in the load register
	task automatic pulse_load;
		repeat (8) @(posedge clk);
		load_pulse <= 1'b1;
		repeat (8) @(posedge clk);
		load_pulse <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// >>> bench/xsc_chain_test.sv
// Self-checking bench of the crosspoint serial configuration chain
`timescale 1ns/100ps
`default_nettype none
`include "xsc_map.svh"

module xsc_chain_test
	import xsc_pkg::*;
;
	logic          clk;
	logic          nrst;
	logic          ser_clk;
	logic          ser_data;
	logic          load_pulse;
	xsc_axi_req_t  req;
	xsc_axi_resp_t resp;
	logic          row_fwd_clock;
	logic          row_fwd_data;
	logic          column_fwd_clock;
	logic          column_fwd_data;
	logic [2:0]    o1, o2, o3, o4;
	logic [3:0]    oen;
	logic [7:0]    osrc;
	logic [29:0]   row_cap = 30'h0;
	logic [29:0]   col_cap = 30'h0;
	logic [11:0]   cfg_exp = 12'h000;
	logic [11:0]   ld_exp = 12'h000;
	logic [31:0]   seed = 32'h73CF728A;
	int            error_cnt = 0;
	int            n_tests = 0;

	xsc_chain xsc_chain_inst (.clk(clk), .nrst(nrst), .ser_clk(ser_clk), .ser_data(ser_data),
		.load_pulse(load_pulse), .axi_req(req), .axi_resp(resp),
		.row_fwd_clock(row_fwd_clock), .row_fwd_data(row_fwd_data),
		.column_fwd_clock(column_fwd_clock), .column_fwd_data(column_fwd_data),
		.output_one_select(o1), .output_two_select(o2), .output_three_select(o3),
		.output_four_select(o4), .output_enable(oen), .output_source(osrc));

	xsc_host_model xsc_host_model_inst (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
		.load_pulse(load_pulse));

	// 250 MHz system clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Collect both forwarded streams on their own clocks
	always @(posedge row_fwd_clock) row_cap <= {row_cap[28:0], row_fwd_data};
	always @(posedge column_fwd_clock) col_cap <= {col_cap[28:0], column_fwd_data};

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Legal codes zero to four only; codes above four would upset the device
	function automatic logic [11:0] rnd_f();
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			rnd_f[3*i +: 3] = 3'(seed % 5);
		end
	endfunction

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_word(input logic [29:0] got, input logic [29:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s word got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic bus_timeout;
		error_cnt++;
		$display("mismatch at %0t: bus answer missing", $time);
		complete_run;
	endtask

	// Write: both channels offered together, each dropped when taken
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		int i;
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(negedge clk);
			ta = req.awvalid && resp.awready;
			tw = req.wvalid && resp.wready;
			tb = resp.bvalid === 1'b1;
			r = resp.bresp;
			@(posedge clk);
			if (ta) req.awvalid <= 1'b0;
			if (tw) req.wvalid <= 1'b0;
			if (tb) begin
				req.bready <= 1'b0;
				break;
			end
		end
		if (i == 100) bus_timeout;
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		int i;
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(negedge clk);
			ta = req.arvalid && resp.arready;
			tr = resp.rvalid === 1'b1;
			d = resp.rdata;
			r = resp.rresp;
			@(posedge clk);
			if (ta) req.arvalid <= 1'b0;
			if (tr) begin
				req.rready <= 1'b0;
				break;
			end
		end
		if (i == 100) bus_timeout;
	endtask

	// Active selection, enables and sources against the fields
	task automatic chk_outs(input logic [11:0] f);
		logic [2:0] c;
		chk_val({20'h0, o1, o2, o3, o4}, {20'h0, f}, "selects");
		for (int i = 0; i < 4; i++) begin
			c = f[11-3*i -: 3];
			chk_val({31'h0, oen[i]}, {31'h0, c != 3'h0}, "enable");
			if (c != 3'h0) chk_val({30'h0, osrc[2*i +: 2]}, {30'h0, 2'(c - 3'h1)}, "source");
		end
	endtask

	// One word through the device, both forwarded copies and the load register
	task automatic run_word(input logic [5:0] fr, input logic [5:0] r, input logic [5:0] c,
		input logic [11:0] f);
		logic v, hit;
		logic [11:0] ef;
		logic [31:0] d;
		logic [1:0] rs;
		v = fr == `XSC_FRAME_LOAD || fr == `XSC_FRAME_READ;
		hit = v && r == 6'h00 && c == 6'h00;
		ef = (hit && fr == `XSC_FRAME_READ) ? cfg_exp : f;
		xsc_host_model_inst.send_word({fr, r, c, f});
		repeat (12) @(posedge clk);
		chk_word(col_cap, {fr, v ? r - 6'h01 : r, c, ef}, "column port");
		chk_word(row_cap, {fr, r, v ? c - 6'h01 : c, ef}, "row port");
		if (hit && fr == `XSC_FRAME_LOAD) ld_exp = f;
		axi_rd(`XSC_OFS_LOADREG, d, rs);
		chk_val(d, {20'h0, ld_exp}, "load register");
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0] rs;
		logic [11:0] f;
		req = '0;
		nrst = 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk_outs(12'h000);
		for (int k = 0; k < 6; k++) begin
			f = (k == 0) ? 12'h29C : (k == 1) ? 12'h000 : rnd_f();
			run_word(`XSC_FRAME_LOAD, 6'h00, 6'h00, f);
			xsc_host_model_inst.pulse_load();
			cfg_exp = ld_exp;
			chk_outs(cfg_exp);
		end
		$display("test write_load done");
		run_word(`XSC_FRAME_LOAD, 6'h01, 6'h00, rnd_f());
		run_word(`XSC_FRAME_LOAD, 6'h00, 6'h3F, rnd_f());
		run_word(6'h1D, 6'h00, 6'h00, rnd_f());
		$display("test no_capture done");
		run_word(`XSC_FRAME_READ, 6'h00, 6'h00, 12'h000);
		run_word(`XSC_FRAME_LOAD, 6'h00, 6'h00, rnd_f());
		run_word(`XSC_FRAME_READ, 6'h02, 6'h00, 12'h000);
		axi_rd(`XSC_OFS_STATUS, d, rs);
		chk_val(d, {23'h0, 1'b0, 1'b1, 2'h0, `XSC_CNT_WORD}, "status");
		$display("test read_back done");
		axi_wr(`XSC_OFS_CTRL, 32'h0000_0000, rs);
		repeat (4) @(posedge clk);
		chk_outs(cfg_exp);
		axi_wr(`XSC_OFS_CTRL, 32'h0000_0001, rs);
		chk_val({30'h0, rs}, {30'h0, `XSC_RESP_OKAY}, "ctrl response");
		cfg_exp = ld_exp;
		repeat (4) @(posedge clk);
		chk_outs(cfg_exp);
		axi_rd(`XSC_OFS_CFG, d, rs);
		chk_val(d, {20'h0, cfg_exp}, "cfg read");
		axi_wr(32'h0000_0010, 32'h0000_0001, rs);
		chk_val({30'h0, rs}, {30'h0, `XSC_RESP_SLVERR}, "unmapped write");
		axi_rd(32'h0000_0010, d, rs);
		chk_val({d[29:0], rs}, {30'h0, `XSC_RESP_SLVERR}, "unmapped read");
		$display("test registers done");
		// Reset in mid-run must clear both registers and still accept a word
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		cfg_exp = `XSC_CFG_RST;
		ld_exp = `XSC_CFG_RST;
		chk_outs(cfg_exp);
		axi_rd(`XSC_OFS_LOADREG, d, rs);
		chk_val(d, {20'h0, ld_exp}, "load register after reset");
		run_word(`XSC_FRAME_LOAD, 6'h00, 6'h00, rnd_f());
		xsc_host_model_inst.pulse_load();
		cfg_exp = ld_exp;
		chk_outs(cfg_exp);
		$display("test mid_reset done");
		complete_run;
	end
endmodule
`default_nettype wire
